// ===== rtl/pm_chan_map.svh
// register offsets, field positions, reset values and timing counts of the power-management mailbox channel
`ifndef PM_CHAN_MAP_SVH
`define PM_CHAN_MAP_SVH
// ****************
// register offsets
// ****************
`define OFS_STATUS    8'h00
`define OFS_DOUT      8'h04
`define OFS_DOUT_SCI  8'h08
`define OFS_DOUT_SMI  8'h0C
`define OFS_DIN       8'h10
`define OFS_DIN_SCI   8'h14
`define OFS_CTL       8'h18
`define OFS_INT_CTL   8'h1C
`define OFS_INT_EN    8'h20
`define OFS_IRQ_CTL   8'h24
`define OFS_HOST_CTL  8'h28
// ****************
// field positions
// ****************
`define ST_OBF        0
`define ST_IBF        1
`define ST_F0         2
`define ST_A2         3
`define CTL_EME       0
`define CTL_IBFIE     1
`define CTL_OBEIE     2
`define CTL_SCI_PULSE_LENGTH_LO   4
`define IC_SMI_PULSE_LENGTH_LO    0
`define IC_FW_SMI_LEVEL_BIT       4
`define IC_FW_SCI_LEVEL_BIT       5
`define IC_SCI_INPUT_SOFT_SET      6
`define IE_IRQ_ROUTE_ENABLE       0
`define IE_SMI_ROUTE_ENABLE       1
`define IE_SCI_ROUTE_ENABLE       2
`define IE_HW_SMI_ENABLE      3
`define IE_HW_SCI_ENABLE      4
`define IRQ_FW        0
`define IRQ_NPOL      1
`define IRQ_MODE_LO   2
`define IRQ_RDBK      5
`define HC_HIE        0
`define HC_IN_FULL_CORE_INT_ENABLE     1
`define HC_OBECIE     2
`define RESET_BYTE    8'h00
// ****************
// timing
// ****************
`define CLK_PERIOD_NS 10
`define PULSE_UNIT_NS 10
`define PULSE_UNIT_CYC ((`PULSE_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ===== rtl/pm_chan_pkg.sv
// types of the power-management mailbox channel
package pm_chan_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       is_cmd;
    logic [7:0] wdata;
  } host_req_t;
  typedef enum logic [1:0] {BUS_IDLE, BUS_WRESP, BUS_RRESP} bus_state_t;
endpackage : pm_chan_pkg

// ===== rtl/pulse_gen.sv
// one-shot active-high pulse of programmable width
`timescale 1ns/10ps
module pulse_gen
  import pm_chan_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       trig,
  input  wire logic [2:0] len,
  output logic            pulse
);
  logic [2:0] cnt;
  // width is len units, at least one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt   <= 3'h0;
      pulse <= 1'b0;
    end else if (trig) begin
      cnt   <= (len == 3'h0) ? 3'h0 : 3'(len - 3'h1);
      pulse <= 1'b1;
    end else if (cnt != 3'h0) begin
      cnt <= 3'(cnt - 3'h1);
    end else begin
      pulse <= 1'b0;
    end
  end
endmodule : pulse_gen

// ===== rtl/irq_gen.sv
// host irq line generator: firmware, pulse or level, with polarity
`timescale 1ns/10ps
module irq_gen
  import pm_chan_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       hw_en,
  input  wire logic       fw_bit,
  input  wire logic       npol,
  input  wire logic [2:0] mode,
  input  wire logic       obf_set,
  input  wire logic       obf,
  input  wire logic       gate,
  output logic            line
);
  logic pulse;
  logic raw;
  pulse_gen u_pulse (
    .aclk    (aclk),
    .aresetn (aresetn),
    .trig    (obf_set && gate),
    .len     (mode),
    .pulse   (pulse)
  );
  // pulse rests high and dips low, level follows output-full
  always_comb begin
    if (mode != 3'h0) raw = ~pulse;
    else              raw = obf && gate;
  end
  // firmware bit as written, or hardware scheme then polarity
  always_ff @(posedge aclk) begin
    if (!aresetn) line <= 1'b0;
    else if (!hw_en) line <= fw_bit;
    else line <= raw ^ npol;
  end
endmodule : irq_gen

// ===== rtl/pm_channel_host_irq.sv
// power-management mailbox channel with host irq, smi and sci generation
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "pm_chan_map.svh"
module pm_channel_host_irq
  import pm_chan_pkg::*;
#(
  parameter bit CHANNEL_ONE = 1'b1
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire host_req_t   host_req,
  output logic [7:0]       host_rdata,
  output logic [7:0]       host_status,
  output logic             host_irq,
  output logic             channel_smi_signal,
  output logic             channel_sci_signal,
  output logic             sci_event_output,
  output logic             core_in_full_int,
  output logic             core_out_empty_int
);
  // ****************
  // registers
  // ****************
  logic [7:0] input_byte_latch;
  logic [7:0] output_byte_latch;
  logic       obf;
  logic       ibf;
  logic       cmd_addr_indicator;
  logic       flag_f0;
  logic [3:0] gen_flags;
  logic [7:0] channel_control_reg;
  logic [7:0] channel_int_control_reg;
  logic [7:0] channel_int_enable_reg;
  logic [7:0] host_irq_control_reg;
  logic [7:0] host_if_control_reg;
  logic       out_full_smi_pending;
  logic       out_full_sci_pending;
  logic       in_empty_sci_pending;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic       aw_have;
  logic       w_have;
  bus_state_t wstate;
  logic       irq_line;
  logic       smi_pulse;
  logic       sci_pulse;

  // decode of a byte offset against the map
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ****************
  // write channel
  // ****************
  logic do_wr;
  logic do_rd;
  logic enhanced_mode_enable;
  logic wr_plain;
  logic wr_smi;
  logic wr_sci;
  logic rd_din;
  logic rd_din_sci;
  logic soft_sci;
  logic obf_set;
  logic host_rd;
  logic host_wr;
  logic wr_ok;
  logic rd_ok;
  logic compat;
  logic irq_gate;

  assign do_wr   = aw_have && w_have && (wstate == BUS_IDLE);
  assign do_rd   = arvalid && arready;
  assign wr_ok   = wstrb[0];
  // compatible mode only on channel 1
  assign enhanced_mode_enable = channel_control_reg[`CTL_EME];
  assign compat  = CHANNEL_ONE && !enhanced_mode_enable;
  assign wr_plain = do_wr && wr_ok && hit(aw_addr, `OFS_DOUT);
  assign wr_smi   = do_wr && wr_ok && hit(aw_addr, `OFS_DOUT_SMI);
  assign wr_sci   = do_wr && wr_ok && hit(aw_addr, `OFS_DOUT_SCI);
  assign rd_din     = do_rd && hit(araddr, `OFS_DIN);
  assign rd_din_sci = do_rd && hit(araddr, `OFS_DIN_SCI);
  assign soft_sci = do_wr && wr_ok && hit(aw_addr, `OFS_INT_CTL) && w_data[`IC_SCI_INPUT_SOFT_SET];
  assign obf_set  = wr_plain || wr_smi || wr_sci;
  assign host_rd  = host_req.rd && !host_req.wr;
  assign host_wr  = host_req.wr;
  assign rd_ok    = 1'b1;
  // irq route gate, the irq route enable bit in both compatible and enhanced mode
  assign irq_gate = channel_int_enable_reg[`IE_IRQ_ROUTE_ENABLE];

  // address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
    end else begin
      if (awvalid && awready) begin
        aw_have <= 1'b1;
        aw_addr <= {awaddr[7:2], 2'b00};
      end else if (do_wr) aw_have <= 1'b0;
      if (wvalid && wready) begin
        w_have <= 1'b1;
        w_data <= wdata;
      end else if (do_wr) w_have <= 1'b0;
    end
  end

  // ready and response handshakes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= 2'b00;
      wstate  <= BUS_IDLE;
    end else begin
      awready <= !aw_have && !(awvalid && awready) && (wstate == BUS_IDLE);
      wready  <= !w_have && !(wvalid && wready) && (wstate == BUS_IDLE);
      case (wstate)
        BUS_IDLE: begin
          if (do_wr) begin
            bvalid <= 1'b1;
            bresp  <= (aw_addr > `OFS_HOST_CTL) ? 2'b10 : 2'b00;
            wstate <= BUS_WRESP;
          end
        end
        BUS_WRESP: begin
          if (bready) begin
            bvalid <= 1'b0;
            wstate <= BUS_IDLE;
          end
        end
        default: wstate <= BUS_IDLE;
      endcase
    end
  end

  // ****************
  // read channel
  // ****************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= 2'b00;
    end else begin
      arready <= !rvalid && !arready && rd_ok;
      if (do_rd) begin
        rvalid <= 1'b1;
        rresp  <= 2'b00;
        rdata  <= 32'h0000_0000;
        case (araddr[7:2])
          6'(`OFS_STATUS   >> 2): rdata[7:0] <= host_status;
          6'(`OFS_DIN      >> 2): rdata[7:0] <= input_byte_latch;
          6'(`OFS_DIN_SCI  >> 2): rdata[7:0] <= input_byte_latch;
          6'(`OFS_CTL      >> 2): rdata[7:0] <= channel_control_reg;
          6'(`OFS_INT_CTL  >> 2): rdata[7:0] <= channel_int_control_reg;
          6'(`OFS_INT_EN   >> 2): rdata[7:0] <= channel_int_enable_reg;
          6'(`OFS_IRQ_CTL  >> 2): rdata[7:0] <= {host_irq_control_reg[7:6], irq_line,
                                                 host_irq_control_reg[4:0]};
          6'(`OFS_HOST_CTL >> 2): rdata[7:0] <= host_if_control_reg;
          6'(`OFS_DOUT     >> 2),
          6'(`OFS_DOUT_SCI >> 2),
          6'(`OFS_DOUT_SMI >> 2): rdata[7:0] <= 8'h00;
          default: rresp <= 2'b10;
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ****************
  // configuration registers
  // ****************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_control_reg     <= `RESET_BYTE;
      channel_int_control_reg <= `RESET_BYTE;
      channel_int_enable_reg  <= `RESET_BYTE;
      host_irq_control_reg    <= `RESET_BYTE;
      host_if_control_reg     <= `RESET_BYTE;
      flag_f0                 <= 1'b0;
      gen_flags               <= 4'h0;
    end else if (do_wr && wr_ok) begin
      if (hit(aw_addr, `OFS_CTL))      channel_control_reg     <= w_data[7:0];
      if (hit(aw_addr, `OFS_INT_CTL))  channel_int_control_reg <= {1'b0, 1'b0, w_data[5:0]};
      if (hit(aw_addr, `OFS_INT_EN))   channel_int_enable_reg  <= w_data[7:0];
      if (hit(aw_addr, `OFS_IRQ_CTL))  host_irq_control_reg    <= {w_data[7:6], 1'b0, w_data[4:0]};
      if (hit(aw_addr, `OFS_HOST_CTL)) host_if_control_reg     <= w_data[7:0];
      if (hit(aw_addr, `OFS_STATUS)) begin
        flag_f0   <= w_data[`ST_F0];
        gen_flags <= w_data[7:4];
      end
    end
  end

  // ****************
  // mailbox latches and flags
  // ****************
  // output latch, output-full; set wins over host read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_byte_latch <= `RESET_BYTE;
      obf               <= 1'b0;
    end else if (obf_set) begin
      output_byte_latch <= w_data[7:0];
      obf               <= 1'b1;
    end else if (host_rd) begin
      obf <= 1'b0;
    end
  end

  // input latch, input-full, command indicator; host set wins over core read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_byte_latch   <= `RESET_BYTE;
      ibf                <= 1'b0;
      cmd_addr_indicator <= 1'b0;
    end else if (host_wr) begin
      input_byte_latch   <= host_req.wdata;
      ibf                <= 1'b1;
      cmd_addr_indicator <= host_req.is_cmd;
    end else if (rd_din || rd_din_sci) begin
      ibf <= 1'b0;
    end
  end

  // internal interrupt pending flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_full_smi_pending <= 1'b0;
      out_full_sci_pending <= 1'b0;
      in_empty_sci_pending <= 1'b0;
    end else begin
      if (wr_smi) out_full_smi_pending <= 1'b1;
      else if (host_rd) out_full_smi_pending <= 1'b0;
      if (wr_sci) out_full_sci_pending <= 1'b1;
      else if (host_rd) out_full_sci_pending <= 1'b0;
      if (rd_din_sci || soft_sci) in_empty_sci_pending <= 1'b1;
      else if (host_wr) in_empty_sci_pending <= 1'b0;
    end
  end

  // ****************
  // host interrupt generation
  // ****************
  irq_gen u_irq (
    .aclk    (aclk),
    .aresetn (aresetn),
    .hw_en   (host_if_control_reg[`HC_HIE]),
    .fw_bit  (host_irq_control_reg[`IRQ_FW]),
    .npol    (host_irq_control_reg[`IRQ_NPOL]),
    .mode    (host_irq_control_reg[`IRQ_MODE_LO +: 3]),
    .obf_set (obf_set),
    .obf     (obf),
    .gate    (irq_gate),
    .line    (irq_line)
  );

  // smi pulse: smi data write, or any output write in compatible mode
  pulse_gen u_smi (
    .aclk    (aclk),
    .aresetn (aresetn),
    .trig    (wr_smi || (compat && obf_set)),
    .len     (channel_int_control_reg[`IC_SMI_PULSE_LENGTH_LO +: 3]),
    .pulse   (smi_pulse)
  );

  // sci pulse: sci write, sci input read, soft set, or compatible output write
  pulse_gen u_sci (
    .aclk    (aclk),
    .aresetn (aresetn),
    .trig    (wr_sci || rd_din_sci || soft_sci || (compat && obf_set)),
    .len     (channel_control_reg[`CTL_SCI_PULSE_LENGTH_LO +: 3]),
    .pulse   (sci_pulse)
  );

  // smi and sci pins, active low, inactive high when route is off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_smi_signal <= 1'b1;
      channel_sci_signal <= 1'b1;
      sci_event_output   <= 1'b0;
    end else begin
      if (!channel_int_enable_reg[`IE_SMI_ROUTE_ENABLE]) channel_smi_signal <= 1'b1;
      else if (channel_int_enable_reg[`IE_HW_SMI_ENABLE]) channel_smi_signal <= ~smi_pulse;
      else channel_smi_signal <= channel_int_control_reg[`IC_FW_SMI_LEVEL_BIT];
      if (!channel_int_enable_reg[`IE_SCI_ROUTE_ENABLE]) channel_sci_signal <= 1'b1;
      else if (channel_int_enable_reg[`IE_HW_SCI_ENABLE]) channel_sci_signal <= ~sci_pulse;
      else channel_sci_signal <= channel_int_control_reg[`IC_FW_SCI_LEVEL_BIT];
      sci_event_output <= channel_int_enable_reg[`IE_SCI_ROUTE_ENABLE] && sci_pulse;
    end
  end

  // ****************
  // host side and core interrupts
  // ****************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_irq           <= 1'b0;
      host_rdata         <= 8'h00;
      host_status        <= 8'h00;
      core_in_full_int   <= 1'b0;
      core_out_empty_int <= 1'b0;
    end else begin
      host_irq    <= irq_line;
      host_rdata  <= output_byte_latch;
      host_status <= {gen_flags, cmd_addr_indicator, flag_f0, ibf, obf};
      core_in_full_int <= ibf && (compat ? host_if_control_reg[`HC_IN_FULL_CORE_INT_ENABLE]
                                         : channel_control_reg[`CTL_IBFIE]);
      core_out_empty_int <= !obf && (compat ? host_if_control_reg[`HC_OBECIE]
                                            : channel_control_reg[`CTL_OBEIE]);
    end
  end

  // ****************
  // checks
  // ****************
  obf_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    obf_set |=> obf) else $error("output-full not set by write");
  obf_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    host_rd && !obf_set |=> !obf) else $error("output-full not cleared by host read");
  ibf_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    host_wr |=> ibf && cmd_addr_indicator == $past(host_req.is_cmd)) else $error("input latch");
  ibf_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_din || rd_din_sci) && !host_wr |=> !ibf) else $error("input-full not cleared");
  smi_pend_a: assert property (@(posedge aclk) disable iff (!aresetn)
    out_full_smi_pending |-> obf) else $error("smi pending without output-full");
  sci_pend_a: assert property (@(posedge aclk) disable iff (!aresetn)
    out_full_sci_pending |-> obf) else $error("sci pending without output-full");
  sci_in_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_din_sci && !host_wr |=> in_empty_sci_pending) else $error("input sci flag");
  smi_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !channel_int_enable_reg[`IE_SMI_ROUTE_ENABLE] |=> channel_smi_signal) else $error("smi not high");
  sci_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !channel_int_enable_reg[`IE_SCI_ROUTE_ENABLE] |=> channel_sci_signal) else $error("sci not high");
  core_in_a: assert property (@(posedge aclk) disable iff (!aresetn)
    core_in_full_int |-> $past(ibf)) else $error("core in-full int without input-full");
  cmd_cov_c: cover property (@(posedge aclk) disable iff (!aresetn) host_wr ##[1:20] rd_din_sci);
  out_cov_c: cover property (@(posedge aclk) disable iff (!aresetn) wr_smi ##[1:20] host_rd);
  sci_cov_c: cover property (@(posedge aclk) disable iff (!aresetn) !channel_sci_signal);
endmodule : pm_channel_host_irq

// ===== testbench/host_model.sv
// host-side model of the mailbox channel: byte writes and data-address reads
`timescale 1ns/10ps
module host_model
  import pm_chan_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic [7:0] host_rdata,
  output host_req_t       host_req
);
  initial host_req = '0;
  // one-cycle write strobe, then the byte lines show the inverse of the last value
  task automatic put(input logic cmd, input logic [7:0] b);
    @(posedge aclk);
    host_req <= '{wr: 1'b1, rd: 1'b0, is_cmd: cmd, wdata: b};
    @(posedge aclk);
    host_req <= '{wr: 1'b0, rd: 1'b0, is_cmd: ~cmd, wdata: ~b};
  endtask : put
  // one-cycle data read, byte taken at the edge that samples the strobe
  task automatic get(output logic [7:0] b);
    @(posedge aclk);
    host_req.rd <= 1'b1;
    @(posedge aclk);
    b = host_rdata;
    host_req.rd <= 1'b0;
  endtask : get
endmodule : host_model

// ===== testbench/pm_channel_host_irq_bench.sv
// self-checking bench of the power-management mailbox channel
`timescale 1ns/10ps
`include "pm_chan_map.svh"
module pm_channel_host_irq_bench;
  import pm_chan_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0, hrd, smi_lo, sci_lo, evt_hi, irq_act, b, g;
  logic [31:0] wdata = 0, rdata, rd_v, seed = 32'hE8B3;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp, resp;
  logic irq_pol = 0, clr = 0, smi, sci, evt, irq, in_int, out_int;
  logic [7:0] hst;
  host_req_t hreq;
  int errors = 0, num_checks = 0;
  always #5 aclk = ~aclk;
  host_model host (.aclk(aclk), .host_rdata(hrd), .host_req(hreq));
  pm_channel_host_irq #(.CHANNEL_ONE(1'b1)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(), .bresp(bresp),
    .bvalid(), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(), .rdata(rdata), .rresp(rresp),
    .rvalid(), .rready(rready), .host_req(hreq), .host_rdata(hrd), .host_status(hst), .host_irq(irq),
    .channel_smi_signal(smi), .channel_sci_signal(sci), .sci_event_output(evt), .core_in_full_int(in_int),
    .core_out_empty_int(out_int));
  // pulse-width counters on the host-side interrupt pins
  always @(posedge aclk) begin
    if (clr) begin
      {smi_lo, sci_lo, evt_hi, irq_act} <= '0;
    end else begin
      smi_lo  <= smi_lo + (smi === 1'b0);
      sci_lo  <= sci_lo + (sci === 1'b0);
      evt_hi  <= evt_hi + (evt === 1'b1);
      irq_act <= irq_act + (irq === irq_pol);
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic test_done;
    if (errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt
  task automatic rnd;
    seed = xs(seed);
    b = seed[7:0];
  endtask : rnd
  task automatic clr_cnt;
    @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
  endtask : clr_cnt
  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic done;
    done = 1'b0;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hF};
    {awvalid, wvalid, bready} <= 3'b111;
    // local done flag: bready itself is still old when the loop is entered
    for (n = 0; n < 100 && !done; n++) begin
      @(posedge aclk);
      if (awvalid && dut.awready) awvalid <= 1'b0;
      if (wvalid && dut.wready) wvalid <= 1'b0;
      if (dut.bvalid) begin
        bready <= 1'b0;
        resp = bresp;
        done = 1'b1;
      end
    end
    if (!done) begin
      errors++;
      test_done();
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    logic done;
    done = 1'b0;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    for (n = 0; n < 100 && !done; n++) begin
      @(posedge aclk);
      if (arvalid && dut.arready) arvalid <= 1'b0;
      if (dut.rvalid) begin
        rready <= 1'b0;
        {rd_v, resp} = {rdata, rresp};
        done = 1'b1;
      end
    end
    if (!done) begin
      errors++;
      test_done();
    end
  endtask : rd
  // output write, wait, count pulses; the caller drains the latch
  task automatic send(input logic [7:0] a);
    rnd();
    clr_cnt();
    wr(a, {24'h0, b});
    wt(12);
  endtask : send
  logic [7:0] out_a [3] = '{`OFS_DOUT, `OFS_DOUT_SMI, `OFS_DOUT_SCI};
  logic [7:0] smi_w [3] = '{8'h00, 8'h02, 8'h00};
  logic [7:0] sci_w [3] = '{8'h00, 8'h00, 8'h05};
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    wt(2);
    check({irq, smi, sci, hst}, {3'b011, 8'h00});
    rd(8'h3C);
    check(resp, 2'b10);
    wr(`OFS_STATUS, 32'h74);
    wt(3);
    check(hst & 8'hF4, 8'h74);
    wr(`OFS_STATUS, 32'h0);
    wr(`OFS_HOST_CTL, 32'h6);
    for (int i = 0; i < 4; i++) begin
      rnd();
      host.put(i[0], b);
      wt(3);
      check({hst[3], hst[1], in_int}, {i[0], 2'b11});
      rd(`OFS_DIN);
      check(rd_v[7:0], b);
      wt(3);
      check({hst[1], in_int}, 2'b00);
    end
    check(out_int, 1'b1);
    wr(`OFS_IRQ_CTL, 32'h1);
    wt(3);
    check(irq, 1'b1);
    rd(`OFS_IRQ_CTL);
    check(rd_v[5], 1'b1);
    wr(`OFS_IRQ_CTL, 32'h0);
    wr(`OFS_INT_EN, 32'h1);
    wr(`OFS_HOST_CTL, 32'h7);
    for (int p = 0; p < 2; p++) begin
      wr(`OFS_IRQ_CTL, p << 1);
      wt(3);
      check(irq, p[0]);
      send(`OFS_DOUT);
      check({hst[0], out_int, irq}, {2'b10, ~p[0]});
      host.get(g);
      wt(3);
      check({g, hst[0], out_int, irq}, {b, 2'b01, p[0]});
    end
    for (int p = 0; p < 2; p++) begin
      wr(`OFS_IRQ_CTL, (3 << 2) | (p << 1));
      irq_pol <= p[0];
      wt(3);
      send(`OFS_DOUT);
      check(irq_act, 8'd3);
      host.get(g);
    end
    wr(`OFS_IRQ_CTL, 32'h0);
    wr(`OFS_INT_EN, 32'h4);
    send(`OFS_DOUT);
    check({irq, evt_hi > 0}, 2'b01);
    host.get(g);
    wr(`OFS_CTL, 32'h51);
    wr(`OFS_INT_CTL, 32'h2);
    wr(`OFS_INT_EN, 32'h1E);
    for (int k = 0; k < 3; k++) begin
      send(out_a[k]);
      check({smi_lo, sci_lo, irq}, {smi_w[k], sci_w[k], 1'b0});
      host.get(g);
    end
    host.put(1'b0, b);
    wt(3);
    clr_cnt();
    rd(`OFS_DIN_SCI);
    wt(12);
    check({sci_lo, hst[1]}, {8'd5, 1'b0});
    host.put(1'b1, b);
    wt(3);
    clr_cnt();
    rd(`OFS_DIN);
    wt(12);
    check(sci_lo, 8'd0);
    clr_cnt();
    wr(`OFS_INT_CTL, 32'h42);
    wt(12);
    check(sci_lo, 8'd5);
    for (int v = 0; v < 3; v++) begin
      wr(`OFS_INT_EN, v < 2 ? 32'h6 : 32'h0);
      wr(`OFS_INT_CTL, v[0] ? 32'h30 : 32'h0);
      wt(3);
      check({smi, sci}, v < 2 ? {2{v[0]}} : 2'b11);
    end
    wr(`OFS_INT_EN, 32'h1);
    send(`OFS_DOUT);
    check(irq, 1'b1);
    host.get(g);
    test_done();
  end
endmodule : pm_channel_host_irq_bench
